// File: flash_host_ctrl.sv
// Host-side controller for a parallel NOR flash, ordered over Avalon-MM.
// Assumes the board makes the high voltage from the flags.
//
// Implementation choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
// Overview of operation
// RULE1 - Select, reset high: standby
// RULE2 - Reset standby exits at once
// RULE3 - Standby floats outputs
// RULE4 - Stable address: low power
// RULE5 - Output enable high floats data
// RULE6 - Reset aborts, ignores cycles
// RULE7 - Reset restores array read
// RULE8 - Host restarts aborted work
// RULE9 - Busy reset holds ready low
// RULE10 - Idle reset ends sooner
// RULE11 - Protected group refuses writes
// RULE12 - Protect: high voltage pulse
// RULE13 - High-voltage reset also protects
// RULE14 - Verify read shows protection
// RULE15 - Identity read shows protection
// RULE16 - Unprotect: high voltage pulse
// RULE17 - Protect all before unprotect
// RULE18 - Unprotected groups read zero
// RULE19 - High-voltage reset lifts protection
// RULE20 - Write-protect low locks boot
// RULE21 - Write-protect high: stored state
// RULE22 - Address zero picks identity code
// RULE23 - Bad sequence: array read
// RULE24 - High voltage as own flags
// RULE25 - Low power keeps data
module flash_host_ctrl #(
    parameter int PROT_PULSE_NS   = 100000,
    parameter int UNPROT_PULSE_NS = 100000000
) (
    input  wire logic                             clk_in,
    input  wire logic                             resetn_in,
    input  wire logic [2:0]                       avs_address_in,
    input  wire logic                             avs_read_in,
    input  wire logic                             avs_write_in,
    input  wire logic [31:0]                      avs_writedata_in,
    output logic      [31:0]                      avs_readdata_out,
    output logic                                  avs_waitrequest_out,
    output logic      [flash_host_pkg::ADDR_W-1:0] flash_addr_out,
    input  wire logic [flash_host_pkg::DATA_W-1:0] flash_data_in,
    output logic      [flash_host_pkg::DATA_W-1:0] flash_data_out,
    output logic                                  flash_data_oe_n_out,
    output logic                                  chip_select_n_out,
    output logic                                  output_enable_n_out,
    output logic                                  write_enable_n_out,
    output logic                                  reset_n_out,
    output logic                                  boot_write_protect_accel_out,
    output logic                                  addr_bit_nine_high_id_voltage_out,
    output logic                                  output_enable_high_id_voltage_out,
    output logic                                  reset_high_id_voltage_out,
    input  wire logic                             ready_busy_in
);
    localparam int DW = flash_host_pkg::DATA_W;
    localparam int AW = flash_host_pkg::ADDR_W;
    localparam int CW = flash_host_pkg::CNT_W;
    localparam int PROT_CYC   = (PROT_PULSE_NS + flash_host_pkg::CLK_PERIOD_NS - 1) / flash_host_pkg::CLK_PERIOD_NS;
    localparam int UNPROT_CYC = (UNPROT_PULSE_NS + flash_host_pkg::CLK_PERIOD_NS - 1) / flash_host_pkg::CLK_PERIOD_NS;

    flash_host_pkg::state_t state_r, state_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [2:0]    op_r, op_nxt;
    logic [AW-1:0] addr_r, addr_nxt, pa_r, pa_nxt;
    logic [DW-1:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt, pd_r, pd_nxt;
    logic          stby_ce_r, stby_ce_nxt, stby_rst_r, stby_rst_nxt;
    logic          wp_r, wp_nxt, rst_hv_r, rst_hv_nxt;
    logic          prot_r, prot_nxt, abort_r, abort_nxt, tmo_r, tmo_nxt;
    logic          warn_r, warn_nxt, seen_r, seen_nxt, emb_r, emb_nxt;
    logic          ack_r, ack_nxt;
    logic [31:0]   rd_r, rd_nxt;
    logic          ce_n_r, ce_n_nxt, oe_n_r, oe_n_nxt, we_n_r, we_n_nxt;
    logic          rst_n_r, rst_n_nxt, a9hv_r, a9hv_nxt, oehv_r, oehv_nxt;
    logic          rsthv_r, rsthv_nxt, doe_n_r, doe_n_nxt;
    logic          wr_go, rb_sync, hv, is_rd, is_prog;
    logic [DW-1:0] din_sync;
    logic [CW-1:0] lim;

    pin_sync_if #(.W(DW + 1)) pins ();

    // Pin inputs pass the filter first.
    assign pins.raw = {ready_busy_in, flash_data_in};
    assign rb_sync  = pins.clean[DW];
    assign din_sync = pins.clean[DW-1:0];

    pin_sync #(.W(DW + 1)) u_sync (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .sig       (pins)
    );

    // One wait state per access keeps decode simple; a request takes effect when waitrequest is low.
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;
    assign avs_readdata_out    = rd_r;
    assign wr_go               = avs_write_in & ack_r;

    // Pin levels come straight from flip-flops to avoid strobe glitches.
    assign flash_addr_out                    = pa_r;
    assign flash_data_out                    = pd_r;
    assign flash_data_oe_n_out               = doe_n_r;
    assign chip_select_n_out                 = ce_n_r;
    assign output_enable_n_out               = oe_n_r;
    assign write_enable_n_out                = we_n_r;
    assign reset_n_out                       = rst_n_r;
    assign boot_write_protect_accel_out      = wp_r;
    assign addr_bit_nine_high_id_voltage_out = a9hv_r;
    assign output_enable_high_id_voltage_out = oehv_r;
    assign reset_high_id_voltage_out         = rsthv_r;

    // Next values of every register.
    always_comb begin
        state_nxt = state_r;   cnt_nxt = cnt_r;     op_nxt = op_r;
        addr_nxt = addr_r;     wdata_nxt = wdata_r; rdata_nxt = rdata_r;
        stby_ce_nxt = stby_ce_r;  stby_rst_nxt = stby_rst_r;
        wp_nxt = wp_r;         rst_hv_nxt = rst_hv_r;
        prot_nxt = prot_r;     abort_nxt = abort_r; tmo_nxt = tmo_r;
        warn_nxt = warn_r;     seen_nxt = seen_r;   emb_nxt = emb_r;
        rd_nxt = rd_r;
        ack_nxt = (avs_read_in | avs_write_in) & ~ack_r;
        lim = emb_r ? CW'(flash_host_pkg::RDY_E_CYC) : CW'(flash_host_pkg::RDY_I_CYC);

        // Register reads; unmapped words read as zero.
        if (ack_nxt && avs_read_in) begin
            if (avs_address_in == flash_host_pkg::REG_CTRL) begin
                rd_nxt = {24'h0, rst_hv_r, wp_r, stby_rst_r, stby_ce_r, op_r, 1'b0};
            end else if (avs_address_in == flash_host_pkg::REG_ADDR) begin
                rd_nxt = 32'(addr_r);
            end else if (avs_address_in == flash_host_pkg::REG_WDATA) begin
                rd_nxt = 32'(wdata_r);
            end else if (avs_address_in == flash_host_pkg::REG_RDATA) begin
                rd_nxt = 32'(rdata_r);
            end else if (avs_address_in == flash_host_pkg::REG_STATUS) begin
                rd_nxt = {26'h0, warn_r, tmo_r, rb_sync, abort_r, prot_r, state_r != flash_host_pkg::ST_IDLE};
            end else begin
                rd_nxt = 32'h0;
            end
        end

        // Register writes; operand writes are ignored while an operation runs.
        if (wr_go) begin
            if (avs_address_in == flash_host_pkg::REG_CTRL) begin
                stby_ce_nxt  = avs_writedata_in[flash_host_pkg::CTRL_STBY_CE];
                stby_rst_nxt = avs_writedata_in[flash_host_pkg::CTRL_STBY_RST];
                // RULE20 RULE21 RULE11 write-protect level
                wp_nxt       = avs_writedata_in[flash_host_pkg::CTRL_WP_HIGH];
                rst_hv_nxt   = avs_writedata_in[flash_host_pkg::CTRL_RST_HV];
                if (state_r == flash_host_pkg::ST_IDLE) begin
                    op_nxt = avs_writedata_in[flash_host_pkg::CTRL_OP_LO +: 3];
                end
            end else if (avs_address_in == flash_host_pkg::REG_ADDR && state_r == flash_host_pkg::ST_IDLE) begin
                addr_nxt = avs_writedata_in[AW-1:0];
            end else if (avs_address_in == flash_host_pkg::REG_WDATA && state_r == flash_host_pkg::ST_IDLE) begin
                wdata_nxt = avs_writedata_in[DW-1:0];
            end else if (avs_address_in == flash_host_pkg::REG_STATUS) begin
                abort_nxt = abort_r & ~avs_writedata_in[flash_host_pkg::ST_ABORTED];
                tmo_nxt   = tmo_r & ~avs_writedata_in[flash_host_pkg::ST_TIMEOUT];
                warn_nxt  = warn_r & ~avs_writedata_in[flash_host_pkg::ST_UNADVISED];
            end
        end

        hv      = (op_r == flash_host_pkg::OP_ID) || (op_r == flash_host_pkg::OP_VERIFY)
                  || (((op_r == flash_host_pkg::OP_PROTECT) || (op_r == flash_host_pkg::OP_UNPROT)) && !rst_hv_r);
        is_rd   = (op_r == flash_host_pkg::OP_READ) || (op_r == flash_host_pkg::OP_ID)
                  || (op_r == flash_host_pkg::OP_VERIFY);
        is_prog = (op_r == flash_host_pkg::OP_PROTECT) || (op_r == flash_host_pkg::OP_UNPROT);

        // Timed phases count down and move on at zero; recover lasts one cycle, and reset wait also ends on ready.
        case (state_r)
            flash_host_pkg::ST_IDLE: begin
                if (wr_go && avs_address_in == flash_host_pkg::REG_CTRL
                    && avs_writedata_in[flash_host_pkg::CTRL_START]) begin
                    if (op_nxt == flash_host_pkg::OP_RESET) begin
                        state_nxt = flash_host_pkg::ST_RST_LOW;
                        cnt_nxt   = CW'(flash_host_pkg::RST_CYC - 1);
                        // RULE7 RULE9 longer busy wait
                        emb_nxt   = ~rb_sync;
                        // RULE8 flag aborted operation
                        if (!rb_sync) begin
                            abort_nxt = 1'b1;
                        end
                    end else begin
                        // RULE2 no recovery wait
                        state_nxt = flash_host_pkg::ST_SETUP;
                        cnt_nxt   = '0;
                        if (op_nxt == flash_host_pkg::OP_ID || op_nxt == flash_host_pkg::OP_VERIFY
                            || ((op_nxt == flash_host_pkg::OP_PROTECT || op_nxt == flash_host_pkg::OP_UNPROT)
                                && !rst_hv_nxt)) begin
                            cnt_nxt = CW'(flash_host_pkg::HV_CYC - 1);
                        end
                        // RULE17 warn on unprotect without protect
                        if (op_nxt == flash_host_pkg::OP_PROTECT) begin
                            seen_nxt = 1'b1;
                        end else if (op_nxt == flash_host_pkg::OP_UNPROT) begin
                            warn_nxt = warn_nxt | ~seen_r;
                            seen_nxt = 1'b0;
                        end
                    end
                end
            end
            flash_host_pkg::ST_SETUP: begin
                if (cnt_r == '0) begin
                    state_nxt = flash_host_pkg::ST_ACTIVE;
                    if (is_rd) begin
                        cnt_nxt = CW'(flash_host_pkg::READ_CYC - 1);
                    end else if (is_prog && !rst_hv_r) begin
                        // RULE12 protect pulse length
                        cnt_nxt = (op_r == flash_host_pkg::OP_PROTECT) ? CW'(PROT_CYC - 1) : CW'(UNPROT_CYC - 1);
                    end else begin
                        // RULE13 ordinary write timing
                        cnt_nxt = CW'(flash_host_pkg::WE_CYC - 1);
                    end
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            flash_host_pkg::ST_ACTIVE: begin
                if (cnt_r == '0) begin
                    state_nxt = flash_host_pkg::ST_RECOVER;
                    if (is_rd) begin
                        rdata_nxt = din_sync;
                    end
                    // RULE14 RULE15 RULE18 protection bit
                    if (op_r == flash_host_pkg::OP_VERIFY
                        || (op_r == flash_host_pkg::OP_READ && addr_r[flash_host_pkg::ADDR_BIT_ONE])) begin
                        prot_nxt = din_sync[flash_host_pkg::DATA_BIT_ZERO];
                    end
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            flash_host_pkg::ST_RECOVER: begin
                state_nxt = flash_host_pkg::ST_IDLE;
            end
            flash_host_pkg::ST_RST_LOW: begin
                // RULE6 hold reset minimum width
                if (cnt_r == '0) begin
                    state_nxt = flash_host_pkg::ST_RST_WAIT;
                    cnt_nxt   = lim - 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            flash_host_pkg::ST_RST_WAIT: begin
                // RULE10 bounded ready wait
                if (rb_sync && (lim - cnt_r) > CW'(flash_host_pkg::RH_CYC)) begin
                    state_nxt = flash_host_pkg::ST_IDLE;
                end else if (cnt_r == '0) begin
                    state_nxt = flash_host_pkg::ST_IDLE;
                    tmo_nxt   = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            // RULE23 stray state idles
            default: begin
                state_nxt = flash_host_pkg::ST_IDLE;
            end
        endcase

        // RULE3 RULE4 RULE5 RULE25 stable address, released data
        ce_n_nxt = 1'b0;   oe_n_nxt = 1'b1;  we_n_nxt = 1'b1;  doe_n_nxt = 1'b1;
        rst_n_nxt = 1'b1;  a9hv_nxt = 1'b0;  oehv_nxt = 1'b0;
        // RULE19 high-voltage reset level
        rsthv_nxt = rst_hv_nxt;
        pa_nxt = addr_r;   pd_nxt = wdata_r;
        if (state_nxt == flash_host_pkg::ST_IDLE) begin
            // RULE1 select high for standby
            ce_n_nxt  = stby_ce_nxt;
            rst_n_nxt = ~stby_rst_nxt;
            rsthv_nxt = rst_hv_nxt & ~stby_rst_nxt;
        end else if (state_nxt == flash_host_pkg::ST_RST_LOW) begin
            ce_n_nxt  = 1'b1;
            rst_n_nxt = 1'b0;
            rsthv_nxt = 1'b0;
        end else if (state_nxt == flash_host_pkg::ST_RST_WAIT) begin
            ce_n_nxt = 1'b1;
        end else begin
            // RULE24 separate high-voltage flags
            a9hv_nxt = hv;
            oehv_nxt = hv && is_prog;
            if (is_rd) begin
                oe_n_nxt = (state_nxt != flash_host_pkg::ST_ACTIVE);
            end else begin
                we_n_nxt  = (state_nxt != flash_host_pkg::ST_ACTIVE);
                doe_n_nxt = (op_r != flash_host_pkg::OP_WRITE);
            end
            if (op_r == flash_host_pkg::OP_ID) begin
                // RULE22 identification address pattern
                pa_nxt[flash_host_pkg::ADDR_BIT_SIX] = 1'b0;
                pa_nxt[flash_host_pkg::ADDR_BIT_ONE] = 1'b0;
            end else if (op_r == flash_host_pkg::OP_VERIFY || op_r == flash_host_pkg::OP_PROTECT) begin
                pa_nxt[flash_host_pkg::ADDR_BIT_SIX]  = 1'b0;
                pa_nxt[flash_host_pkg::ADDR_BIT_ONE]  = 1'b1;
                pa_nxt[flash_host_pkg::ADDR_BIT_ZERO] = 1'b0;
            end else if (op_r == flash_host_pkg::OP_UNPROT) begin
                // RULE16 unprotect address pattern
                pa_nxt[flash_host_pkg::ADDR_BIT_SIX]  = 1'b1;
                pa_nxt[flash_host_pkg::ADDR_BIT_ONE]  = 1'b1;
                pa_nxt[flash_host_pkg::ADDR_BIT_ZERO] = 1'b0;
            end
        end
    end

    // Registers only; the flash sees reset low until the first edge.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_r <= flash_host_pkg::ST_IDLE;
            cnt_r <= '0;       op_r <= flash_host_pkg::OP_READ;
            addr_r <= '0;      wdata_r <= '0;     rdata_r <= '0;
            stby_ce_r <= 1'b0; stby_rst_r <= 1'b0; wp_r <= 1'b1;  rst_hv_r <= 1'b0;
            prot_r <= 1'b0;    abort_r <= 1'b0;   tmo_r <= 1'b0;
            warn_r <= 1'b0;    seen_r <= 1'b0;    emb_r <= 1'b0;
            ack_r <= 1'b0;     rd_r <= '0;
            ce_n_r <= 1'b1;    oe_n_r <= 1'b1;    we_n_r <= 1'b1;  rst_n_r <= 1'b0;
            a9hv_r <= 1'b0;    oehv_r <= 1'b0;    rsthv_r <= 1'b0; doe_n_r <= 1'b1;
            pa_r <= '0;        pd_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;     op_r <= op_nxt;
            addr_r <= addr_nxt;   wdata_r <= wdata_nxt; rdata_r <= rdata_nxt;
            stby_ce_r <= stby_ce_nxt; stby_rst_r <= stby_rst_nxt;
            wp_r <= wp_nxt;       rst_hv_r <= rst_hv_nxt;
            prot_r <= prot_nxt;   abort_r <= abort_nxt; tmo_r <= tmo_nxt;
            warn_r <= warn_nxt;   seen_r <= seen_nxt;   emb_r <= emb_nxt;
            ack_r <= ack_nxt;     rd_r <= rd_nxt;
            ce_n_r <= ce_n_nxt;   oe_n_r <= oe_n_nxt;   we_n_r <= we_n_nxt; rst_n_r <= rst_n_nxt;
            a9hv_r <= a9hv_nxt;   oehv_r <= oehv_nxt;   rsthv_r <= rsthv_nxt; doe_n_r <= doe_n_nxt;
            pa_r <= pa_nxt;       pd_r <= pd_nxt;
        end
    end
endmodule

// File: flash_host_pkg.sv
// Constants of the flash host controller.
// Assumes a 25 MHz clock and a word-addressed Avalon-MM port.
package flash_host_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int ADDR_W        = 21;
    localparam int DATA_W        = 16;
    localparam int CNT_W         = 24;
    localparam int SYNC_LAT      = 4;
    // Pin timing in nanoseconds; cycle counts derive from these.
    localparam int READ_ACCESS_TIME_NS        = 70;
    localparam int RESET_PULSE_MIN_WIDTH_NS   = 500;
    localparam int RESET_HIGH_TO_READ_TIME_NS = 50;
    localparam int WE_PULSE_NS                = 35;
    localparam int HV_SETUP_NS                = 4000;
    localparam int READY_EMBEDDED_NS          = 20000;
    localparam int READY_IDLE_NS              = 500;
    localparam int READ_CYC  = (READ_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT;
    localparam int RST_CYC   = (RESET_PULSE_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RH_CYC    = (RESET_HIGH_TO_READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_CYC    = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HV_CYC    = (HV_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RDY_E_CYC = READY_EMBEDDED_NS / CLK_PERIOD_NS;
    localparam int RDY_I_CYC = READY_IDLE_NS / CLK_PERIOD_NS;
    // Register word indices on the Avalon port.
    localparam logic [2:0] REG_CTRL   = 3'h0;
    localparam logic [2:0] REG_ADDR   = 3'h1;
    localparam logic [2:0] REG_WDATA  = 3'h2;
    localparam logic [2:0] REG_RDATA  = 3'h3;
    localparam logic [2:0] REG_STATUS = 3'h4;
    // Control register fields.
    localparam int CTRL_START    = 0;
    localparam int CTRL_OP_LO    = 1;
    localparam int CTRL_STBY_CE  = 4;
    localparam int CTRL_STBY_RST = 5;
    localparam int CTRL_WP_HIGH  = 6;
    localparam int CTRL_RST_HV   = 7;
    // Status register fields; sticky ones clear on a written one.
    localparam int ST_BUSY      = 0;
    localparam int ST_PROTECTED = 1;
    localparam int ST_ABORTED   = 2;
    localparam int ST_READY     = 3;
    localparam int ST_TIMEOUT   = 4;
    localparam int ST_UNADVISED = 5;
    // Operation codes written into the control register.
    localparam logic [2:0] OP_READ    = 3'h0;
    localparam logic [2:0] OP_WRITE   = 3'h1;
    localparam logic [2:0] OP_ID      = 3'h2;
    localparam logic [2:0] OP_VERIFY  = 3'h3;
    localparam logic [2:0] OP_PROTECT = 3'h4;
    localparam logic [2:0] OP_UNPROT  = 3'h5;
    localparam logic [2:0] OP_RESET   = 3'h6;
    // Address and data bit positions of the special modes.
    localparam int ADDR_BIT_NINE = 9;
    localparam int ADDR_BIT_SIX  = 6;
    localparam int ADDR_BIT_ONE  = 1;
    localparam int ADDR_BIT_ZERO = 0;
    localparam int DATA_BIT_ZERO = 0;
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_ACTIVE, ST_RECOVER, ST_RST_LOW, ST_RST_WAIT
    } state_t;
endpackage

// File: pin_sync_if.sv
// Carries raw pin levels into the filter and cleaned levels back out.
// Assumes both ends run on the controller clock.
`timescale 1ns/1ps
interface pin_sync_if #(parameter int W = 17);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport filt (input raw, output clean);
    modport user (output raw, input clean);
endinterface

// File: pin_sync.sv
// Three-stage input filter for pins that change outside the clock domain.
// Assumes asynchronous inputs; a change counts once stages two and three agree.
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 17
) (
    input  wire logic clk_in,
    input  wire logic resetn_in,
    pin_sync_if.filt  sig
);
    logic [W-1:0] s1_r, s2_r, s3_r, clean_r;
    logic [W-1:0] clean_nxt;

    assign sig.clean = clean_r;

    // Per bit, the cleaned level only follows when the two later stages match.
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_comb begin
                clean_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : clean_r[i];
            end
        end
    endgenerate

    // The first stage feeds only the second, to contain metastability.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s1_r    <= '0;
            s2_r    <= '0;
            s3_r    <= '0;
            clean_r <= '0;
        end else begin
            s1_r    <= sig.raw;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            clean_r <= clean_nxt;
        end
    end
endmodule

// File: flash_host_props.sv
// Pin checks of the flash host controller.
// Assumes one clock.
`timescale 1ns/1ps
module flash_host_props (
    input wire logic        clk_in,
    input wire logic        resetn_in,
    input wire logic [20:0] flash_addr_out,
    input wire logic        flash_data_oe_n_out,
    input wire logic        chip_select_n_out,
    input wire logic        output_enable_n_out,
    input wire logic        write_enable_n_out,
    input wire logic        reset_n_out,
    input wire logic        addr_bit_nine_high_id_voltage_out,
    input wire logic        output_enable_high_id_voltage_out,
    input wire logic        reset_high_id_voltage_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    wire hv9 = addr_bit_nine_high_id_voltage_out;
    wire ov = output_enable_high_id_voltage_out;
    wire rd = !output_enable_n_out;
    // A shorter reset pulse may not abort the device.
    sequence rst_low; !reset_n_out[*8]; endsequence
    hv_setup_a: assert property ($fell(write_enable_n_out) && ov |-> $past(ov, 8) && hv9 && !chip_select_n_out)
        else $error("setup missing");
    pulse_addr_a: assert property (ov && !write_enable_n_out && !$past(write_enable_n_out) |-> $stable(flash_addr_out))
        else $error("address moved");
    verify_pins_a: assert property (hv9 && rd |-> write_enable_n_out && !chip_select_n_out)
        else $error("verify levels");
    id_addr_a: assert property (hv9 && rd |-> !flash_addr_out[6] && !ov)
        else $error("id address");
    no_contend_a: assert property (rd |-> flash_data_oe_n_out)
        else $error("contention");
    reset_width_a: assert property ($fell(reset_n_out) |=> rst_low)
        else $error("reset short");
    reset_quiet_a: assert property (!reset_n_out |-> !rd && write_enable_n_out)
        else $error("cycle in reset");
    hv_reset_a: assert property (reset_high_id_voltage_out |-> reset_n_out && !hv9 && !ov)
        else $error("hv reset levels");
endmodule
bind flash_host_ctrl flash_host_props props (.*);

// File: flash_dev_model.sv
// Flash model with one protection group; identity codes are arbitrary.
// Assumes high voltage comes as flags.
`timescale 1ns/1ps
module flash_dev_model (
    input  wire logic [20:0] flash_addr_out,
    input  wire logic        chip_select_n_out,
    input  wire logic        output_enable_n_out,
    input  wire logic        write_enable_n_out,
    input  wire logic        reset_n_out,
    input  wire logic        addr_bit_nine_high_id_voltage_out,
    input  wire logic        output_enable_high_id_voltage_out,
    input  wire logic        reset_high_id_voltage_out,
    output logic      [15:0] flash_data_in,
    output logic             ready_busy_in
);
    logic        prot_r = 1'b0;
    logic [15:0] last_r = 16'h0;
    logic        drv;
    always @(posedge write_enable_n_out)
        if (!chip_select_n_out && (reset_high_id_voltage_out || output_enable_high_id_voltage_out))
            prot_r <= !flash_addr_out[6];
    always @* begin
        drv = !chip_select_n_out && !output_enable_n_out && reset_n_out;
        if (drv)
            last_r = !addr_bit_nine_high_id_voltage_out ? flash_addr_out[15:0] ^ 16'h5a5a :
                     flash_addr_out[1] ? {15'h0, prot_r} : flash_addr_out[0] ? 16'h0b3c : 16'h00a5;
        flash_data_in = drv ? last_r : ~last_r; // Released lines must not keep the old value.
    end
    assign ready_busy_in = reset_n_out;
endmodule

// File: tb_flash_host_ctrl.sv
// Bench of the flash host controller; identity codes are arbitrary.
// Assumes the checker binds itself.
`timescale 1ns/1ps
module tb_flash_host_ctrl;
    logic clk_in, resetn_in, avs_read_in, avs_write_in, avs_waitrequest_out, ready_busy_in;
    logic [2:0] avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, rd, seed;
    logic [20:0] flash_addr_out;
    logic [15:0] flash_data_in, flash_data_out;
    logic flash_data_oe_n_out, chip_select_n_out, output_enable_n_out, write_enable_n_out, reset_n_out;
    logic boot_write_protect_accel_out, addr_bit_nine_high_id_voltage_out;
    logic output_enable_high_id_voltage_out, reset_high_id_voltage_out;
    int n_fail = 0, checks = 0;
    flash_host_ctrl #(.PROT_PULSE_NS(200), .UNPROT_PULSE_NS(400)) dut (.*);
    flash_dev_model dev (.*);
    initial begin
        clk_in = 0;
        forever #20 clk_in = ~clk_in;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One Avalon access; the request stands until waitrequest is seen low.
    task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge clk_in);
        {avs_write_in, avs_read_in, avs_address_in, avs_writedata_in} <= {w, !w, a, d};
        do begin
            @(posedge clk_in);
            k++;
        end while (avs_waitrequest_out !== 1'b0 && k < 50);
        rd = avs_readdata_out;
        {avs_write_in, avs_read_in} <= 2'b0;
        chk("waitrequest", 0, avs_waitrequest_out);
    endtask
    // Starts one operation with the boot lock released, then polls busy.
    task automatic op(input logic [2:0] o, input logic [20:0] a);
        int k = 0;
        bus(1, flash_host_pkg::REG_ADDR, {11'h0, a});
        bus(1, flash_host_pkg::REG_CTRL, {25'h0, 3'b100, o, 1'b1});
        do begin
            bus(0, flash_host_pkg::REG_STATUS, 0);
            k++;
        end while (rd[0] !== 1'b0 && k < 2000);
        chk("busy", 0, rd[0]);
    endtask
    task automatic close_out;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #1ms;
        n_fail++;
        close_out;
    end
    initial begin
        {resetn_in, avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = '0;
        seed = 32'h2b71ce10;
        repeat (10) @(posedge clk_in);
        resetn_in <= 1;
        bus(1, flash_host_pkg::REG_CTRL, 32'h50);
        // Random reads, the first from standby.
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            if (i == 4) op(flash_host_pkg::OP_RESET, 0);
            op(flash_host_pkg::OP_READ, seed[20:0]);
            bus(0, flash_host_pkg::REG_RDATA, 0);
            chk("rdata", {16'h0, seed[15:0] ^ 16'h5a5a}, rd);
        end
        for (int i = 0; i < 2; i++) begin
            op(flash_host_pkg::OP_ID, 21'(i));
            bus(0, flash_host_pkg::REG_RDATA, 0);
            chk("id", i ? 32'h0b3c : 32'h00a5, rd);
        end
        for (int i = 0; i < 5; i++) begin
            op(i == 1 ? flash_host_pkg::OP_PROTECT : i == 3 ? flash_host_pkg::OP_UNPROT : flash_host_pkg::OP_VERIFY, 0);
            if (i % 2 == 0) chk("protected", 32'(i == 2), {31'h0, rd[1]});
        end
        bus(1, flash_host_pkg::REG_CTRL, 32'hc0);
        repeat (3) @(posedge clk_in);
        chk("rst_hv", 1, {31'h0, reset_high_id_voltage_out});
        bus(0, 3'h7, 32'h1);
        chk("unmapped", 0, rd);
        close_out;
    end
endmodule
